// [inc/booster_pkg.sv]
// Purpose: shared constants and types for the power-stage control block
// Assumes: 125 MHz system clock, 8-bit register port
// Notes:   offsets are the register addresses seen on the register port

// ************************************************************
// package
// ************************************************************
package booster_pkg;

  // register addresses
  localparam logic [7:0] STATUS_ADDR = 8'h00;
  localparam logic [7:0] PROF_A_ADDR = 8'h07;
  localparam logic [7:0] PROF_B_ADDR = 8'h08;
  localparam logic [7:0] VSET_ADDR   = 8'h09;
  localparam logic [7:0] CFG_ADDR    = 8'h10;
  localparam logic [7:0] VFIX_ADDR   = 8'h11;
  localparam logic [7:0] MARG_ADDR   = 8'h13;

  // field positions
  localparam int ALARM_BIT = 5;
  localparam int FLOAT_BIT = 4;

  // values after reset, optimizer limits and profile count
  localparam logic [3:0] VSET_RST   = 4'h6;
  localparam logic [5:0] PROF_RST   = 6'h01;
  localparam logic [1:0] MARG_RST   = 2'h3;
  localparam logic [3:0] VFIX_RST   = 4'h0;
  localparam logic       FLOAT_RST  = 1'b0;
  localparam logic [3:0] LEARN_MAX  = 4'hF;
  localparam logic [3:0] LEARN_MIN  = 4'h0;
  localparam int         PROF_COUNT = 63;

  // switching timing
  localparam int CLK_PERIOD_PS = 8000;
  localparam int SW_PERIOD_NS  = 1000;
  localparam int SW_PERIOD_CYC = (SW_PERIOD_NS * 1000) / CLK_PERIOD_PS;
  localparam logic [6:0] PER_LAST = 7'(SW_PERIOD_CYC - 1);
  localparam logic [6:0] PRI_MAX  = 7'(SW_PERIOD_CYC - 10);

  // power state reported by the state machine
  typedef enum logic [1:0] {ST_STANDBY, ST_CHARGE, ST_ACTIVE} pwr_state_t;

  // converter phase
  typedef enum logic [1:0] {PH_IDLE, PH_PRIMARY, PH_DEAD, PH_SECONDARY} phase_t;

endpackage

// [logic/phase_gen.sv]
// Purpose: fixed-frequency peak-current phase sequencer
// Assumes: peak and zero-cross comparators are synchronous to mclk_i
// Notes:   one dead cycle from primary to secondary; at least one idle cycle from secondary to the next primary

`timescale 1ns/1ps

// ************************************************************
// phase sequencer
// ************************************************************
module phase_gen (
  input  wire logic                mclk_i,
  input  wire logic                arst_n_i,
  input  wire logic                run_i,
  input  wire logic                peak_trip_i,
  input  wire logic                zero_cross_i,
  output booster_pkg::phase_t      phase_o
);

  typedef struct packed {
    logic [6:0]          cnt;
    booster_pkg::phase_t ph;
  } pg_t;

  pg_t s;
  pg_t next_s;

  always_comb begin
    next_s = s;
    next_s.cnt = (s.cnt == booster_pkg::PER_LAST) ? 7'h00 : s.cnt + 7'h01;
    unique case (s.ph)
      booster_pkg::PH_IDLE: begin
        if (run_i && s.cnt == booster_pkg::PER_LAST) begin
          next_s.ph = booster_pkg::PH_PRIMARY;
        end
      end
      booster_pkg::PH_PRIMARY: begin
        if (!run_i) begin
          next_s.ph = booster_pkg::PH_IDLE;
        end else if (peak_trip_i || s.cnt == booster_pkg::PRI_MAX) begin
          next_s.ph = booster_pkg::PH_DEAD;
        end
      end
      booster_pkg::PH_DEAD: begin
        next_s.ph = run_i ? booster_pkg::PH_SECONDARY : booster_pkg::PH_IDLE;
      end
      booster_pkg::PH_SECONDARY: begin
        // zero cross ends the secondary phase early at light load, else it runs until one cycle before period end
        if (!run_i || zero_cross_i || s.cnt == booster_pkg::PER_LAST - 7'h01) begin
          next_s.ph = booster_pkg::PH_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s <= '{cnt: 7'h00, ph: booster_pkg::PH_IDLE};
    end else begin
      s <= next_s;
    end
  end

  assign phase_o = s.ph;

endmodule // phase_gen

// [logic/power_stage_ctl.sv]
// Purpose: alarm, switch routing, output level and optimizer control
// Assumes: power state and analog comparators arrive synchronous to mclk_i
// Notes:   all outputs are flops; switch sets open for a cycle between converter phases

`timescale 1ns/1ps

// ************************************************************
// power stage control
// ************************************************************
module power_stage_ctl (
  input  wire logic                    mclk_i,
  input  wire logic                    arst_n_i,
  input  wire logic [7:0]              addr_i,
  input  wire logic [7:0]              wdata_i,
  input  wire logic                    wr_i,
  input  wire logic                    rd_i,
  output logic [7:0]                   rdata_o,
  input  booster_pkg::pwr_state_t      pwr_state_i,
  input  wire logic                    out_below_target_i,
  input  wire logic                    storage_below_precharge_i,
  input  wire logic                    storage_above_output_i,
  input  wire logic [3:0]              storage_voltage_i,
  input  wire logic                    residual_above_margin_i,
  input  wire logic                    peak_trip_i,
  input  wire logic                    zero_cross_i,
  output logic                         ready_o,
  output logic                         precharge_switch_o,
  output logic                         precharge_leg_switch_o,
  output logic                         bridge_switch_a_o,
  output logic                         bridge_switch_b_o,
  output logic                         bridge_switch_c_o,
  output logic                         bridge_switch_d_o,
  output logic                         battery_to_permanent_switch_o,
  output logic                         switched_to_permanent_switch_o,
  output logic                         battery_to_switched_switch_o,
  output logic                         regulator_to_switched_switch_o,
  output logic [3:0]                   output_level_o,
  output logic [3:0]                   learned_charge_target_o,
  output logic [1:0]                   opt_margin_o,
  output logic                         end_of_charge_o
);

  typedef struct packed {
    logic                    alarm;
    logic                    ready;
    booster_pkg::pwr_state_t prev_st;
    logic [5:0]              prof;
    logic [3:0]              vset;
    logic                    float_en;
    logic [3:0]              vfix;
    logic [1:0]              margin;
    logic [63:1][3:0]        learn;
    logic [3:0]              target;
    logic                    eoc;
    logic                    pchg;
    logic                    leg;
    logic                    sw_a;
    logic                    sw_b;
    logic                    sw_c;
    logic                    sw_d;
    logic                    bat_perm;
    logic                    sw_perm;
    logic                    bat_sw;
    logic                    reg_sw;
    logic [7:0]              rdata;
  } ctl_t;

  localparam ctl_t RST_S = '{
    ready:    1'b1,
    prev_st:  booster_pkg::ST_STANDBY,
    prof:     booster_pkg::PROF_RST,
    vset:     booster_pkg::VSET_RST,
    float_en: booster_pkg::FLOAT_RST,
    vfix:     booster_pkg::VFIX_RST,
    margin:   booster_pkg::MARG_RST,
    learn:    {booster_pkg::PROF_COUNT{booster_pkg::LEARN_MAX}},
    bat_perm: 1'b1,
    bat_sw:   1'b1,
    default:  '0
  };

  ctl_t                s;
  ctl_t                next_s;
  booster_pkg::phase_t phase;
  logic [3:0]          learn_upd [1:63];
  logic                is_active;
  logic                is_charge;
  logic                opt_end;
  logic                boost_run;

  // ************************************************************
  // converter phase timing
  // ************************************************************
  assign is_active = (pwr_state_i == booster_pkg::ST_ACTIVE);
  assign is_charge = (pwr_state_i == booster_pkg::ST_CHARGE);
  assign boost_run = is_active || (is_charge && !storage_below_precharge_i);

  phase_gen u_phase (
    .mclk_i       (mclk_i),
    .arst_n_i     (arst_n_i),
    .run_i        (boost_run),
    .peak_trip_i  (peak_trip_i),
    .zero_cross_i (zero_cross_i),
    .phase_o      (phase)
  );

  // ************************************************************
  // optimizer profile storage
  // ************************************************************
  assign opt_end = (s.prev_st == booster_pkg::ST_ACTIVE) && !is_active && (s.prof != 6'h00);

  for (genvar i = 1; i <= booster_pkg::PROF_COUNT; i++) begin : g_learn
    logic hit;
    assign hit = opt_end && (s.prof == 6'(i));
    assign learn_upd[i] = !hit ? s.learn[i] :
                          residual_above_margin_i ?
                            ((s.learn[i] == booster_pkg::LEARN_MIN) ? s.learn[i] : s.learn[i] - 4'h1) :
                            ((s.learn[i] == booster_pkg::LEARN_MAX) ? s.learn[i] : s.learn[i] + 4'h1);
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    logic want_bat_sw;
    logic want_reg_sw;
    logic want_bat_perm;
    logic want_sw_perm;
    want_bat_sw   = 1'b0;
    want_reg_sw   = 1'b0;
    want_bat_perm = 1'b0;
    want_sw_perm  = 1'b0;
    next_s = s;
    next_s.prev_st = pwr_state_i;

    // alarm: set wins, cleared only as Charge begins
    if (is_charge && s.prev_st != booster_pkg::ST_CHARGE) begin
      next_s.alarm = 1'b0;
    end
    if (is_active && out_below_target_i) begin
      next_s.alarm = 1'b1;
    end
    next_s.ready = !next_s.alarm;

    // register writes
    if (wr_i) begin
      unique case (addr_i)
        booster_pkg::PROF_A_ADDR, booster_pkg::PROF_B_ADDR: begin
          next_s.prof = wdata_i[5:0];
        end
        booster_pkg::VSET_ADDR: begin
          next_s.vset = wdata_i[3:0];
        end
        booster_pkg::CFG_ADDR: begin
          next_s.float_en = wdata_i[booster_pkg::FLOAT_BIT];
        end
        booster_pkg::VFIX_ADDR: begin
          next_s.vfix = wdata_i[3:0];
        end
        booster_pkg::MARG_ADDR: begin
          next_s.margin = wdata_i[1:0];
        end
        default: begin
        end
      endcase
    end

    // register reads, data valid the next cycle only
    next_s.rdata = 8'h00;
    if (rd_i) begin
      unique case (addr_i)
        booster_pkg::STATUS_ADDR: begin
          next_s.rdata[booster_pkg::ALARM_BIT] = s.alarm;
        end
        booster_pkg::PROF_A_ADDR, booster_pkg::PROF_B_ADDR: begin
          next_s.rdata = {2'h0, s.prof};
        end
        booster_pkg::VSET_ADDR: begin
          next_s.rdata = {4'h0, s.vset};
        end
        booster_pkg::CFG_ADDR: begin
          next_s.rdata[booster_pkg::FLOAT_BIT] = s.float_en;
        end
        booster_pkg::VFIX_ADDR: begin
          next_s.rdata = {4'h0, s.vfix};
        end
        booster_pkg::MARG_ADDR: begin
          next_s.rdata = {6'h00, s.margin};
        end
        default: begin
        end
      endcase
    end

    // optimizer targets and end of charge
    for (int i = 1; i <= booster_pkg::PROF_COUNT; i++) begin
      next_s.learn[i] = learn_upd[i];
    end
    next_s.target = (s.prof == 6'h00) ? s.vfix : s.learn[s.prof];
    next_s.eoc = is_charge && !storage_below_precharge_i && (storage_voltage_i >= s.target);

    // bridge switch selection
    next_s.pchg = 1'b0;
    next_s.leg  = 1'b0;
    next_s.sw_a = 1'b0;
    next_s.sw_b = 1'b0;
    next_s.sw_c = 1'b0;
    next_s.sw_d = 1'b0;
    unique case (pwr_state_i)
      booster_pkg::ST_STANDBY: begin
        want_bat_perm = 1'b1;
        want_bat_sw   = !s.float_en;
      end
      booster_pkg::ST_CHARGE: begin
        want_bat_perm = 1'b1;
        want_bat_sw   = !s.float_en;
        if (storage_below_precharge_i) begin
          next_s.pchg = 1'b1;
        end else if (phase == booster_pkg::PH_PRIMARY) begin
          next_s.leg  = 1'b1;
          next_s.sw_c = 1'b1;
        end else if (phase == booster_pkg::PH_SECONDARY) begin
          next_s.sw_b = 1'b1;
          next_s.sw_d = 1'b1;
        end
      end
      booster_pkg::ST_ACTIVE: begin
        want_sw_perm = 1'b1;
        want_reg_sw  = 1'b1;
        if (phase == booster_pkg::PH_PRIMARY) begin
          next_s.sw_a = storage_above_output_i;
          next_s.sw_b = !storage_above_output_i;
          next_s.sw_d = 1'b1;
        end else if (phase == booster_pkg::PH_SECONDARY) begin
          next_s.sw_c = storage_above_output_i;
          next_s.sw_a = !storage_above_output_i;
          next_s.sw_d = 1'b1;
        end
      end
      default: begin
        want_bat_perm = 1'b1;
      end
    endcase

    // break before make on both outputs
    next_s.bat_perm = want_bat_perm && !s.sw_perm;
    next_s.sw_perm  = want_sw_perm && !s.bat_perm;
    next_s.bat_sw   = want_bat_sw && !s.reg_sw;
    next_s.reg_sw   = want_reg_sw && !s.bat_sw;
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s <= RST_S;
    end else begin
      s <= next_s;
    end
  end

  assign rdata_o                        = s.rdata;
  assign ready_o                        = s.ready;
  assign precharge_switch_o             = s.pchg;
  assign precharge_leg_switch_o         = s.leg;
  assign bridge_switch_a_o              = s.sw_a;
  assign bridge_switch_b_o              = s.sw_b;
  assign bridge_switch_c_o              = s.sw_c;
  assign bridge_switch_d_o              = s.sw_d;
  assign battery_to_permanent_switch_o  = s.bat_perm;
  assign switched_to_permanent_switch_o = s.sw_perm;
  assign battery_to_switched_switch_o   = s.bat_sw;
  assign regulator_to_switched_switch_o = s.reg_sw;
  assign output_level_o                 = s.vset;
  assign learned_charge_target_o        = s.target;
  assign opt_margin_o                   = s.margin;
  assign end_of_charge_o                = s.eoc;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!arst_n_i);

  logic [7:0] since_pri;
  logic       pri_seen;
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      since_pri <= 8'h00;
      pri_seen  <= 1'b0;
    end else if (phase == booster_pkg::PH_PRIMARY && $past(phase) != booster_pkg::PH_PRIMARY) begin
      since_pri <= 8'h01;
      pri_seen  <= 1'b1;
    end else if (since_pri != 8'hFF) begin
      since_pri <= since_pri + 8'h01;
    end
  end

  alarm_set_a: assert property (is_active && out_below_target_i |=> s.alarm && !ready_o)
    else $error("alarm not raised on low output");
  ready_low_a: assert property (rdata_o[booster_pkg::ALARM_BIT] && $past(rd_i)
                                && $past(addr_i) == booster_pkg::STATUS_ADDR && !$past(is_charge) |-> !ready_o)
    else $error("ready high while alarm reads set");
  alarm_hold_a: assert property (s.alarm && !is_charge |=> s.alarm)
    else $error("alarm dropped outside charge start");
  sw_period_a: assert property (phase == booster_pkg::PH_PRIMARY && $past(phase) != booster_pkg::PH_PRIMARY
                                && pri_seen |-> since_pri >= 8'(booster_pkg::SW_PERIOD_CYC))
    else $error("switching period shorter than 1 us");
  precharge_a: assert property (is_charge && storage_below_precharge_i |=> precharge_switch_o
                                && !bridge_switch_b_o && !bridge_switch_d_o)
    else $error("precharge path wrong");
  chg_boost_a: assert property (is_charge && !storage_below_precharge_i && phase == booster_pkg::PH_PRIMARY
                                |=> precharge_leg_switch_o && bridge_switch_c_o && !bridge_switch_d_o)
    else $error("charge boost primary phase wrong");
  act_buck_a: assert property (is_active && storage_above_output_i && phase == booster_pkg::PH_SECONDARY
                               |=> bridge_switch_c_o && bridge_switch_d_o && !bridge_switch_a_o)
    else $error("active buck secondary phase wrong");
  act_boost_a: assert property (is_active && !storage_above_output_i && phase == booster_pkg::PH_PRIMARY
                                |=> bridge_switch_b_o && bridge_switch_d_o && !bridge_switch_a_o)
    else $error("active boost primary phase wrong");
  perm_excl_a: assert property (!(battery_to_permanent_switch_o && switched_to_permanent_switch_o)
                                && !(battery_to_switched_switch_o && regulator_to_switched_switch_o))
    else $error("two sources on one output");
  float_route_a: assert property (!is_active && !s.float_en [*3] |-> battery_to_switched_switch_o)
    else $error("switched output not on battery");
  float_hiz_a: assert property (!is_active && s.float_en |=> !battery_to_switched_switch_o
                                && !regulator_to_switched_switch_o)
    else $error("switched output not floating");

endmodule // power_stage_ctl

// [test/storage_load_model.sv]
// Purpose: far-side model: storage capacitor, battery and system loads
// Assumes: switch outputs of the control block arrive registered on mclk_i
// Notes:   cap_i is the storage level code; heavy_i loads the switched output

`timescale 1ns/1ps

// ************************************************************
// storage and load model
// ************************************************************
module storage_load_model #(
  parameter logic [3:0] PRECHARGE_CODE = 4'h3,
  parameter logic [3:0] TRIP_CNT       = 4'hA,
  parameter logic [3:0] EMPTY_CNT      = 4'h6
) (
  input  wire logic       mclk_i,
  input  wire logic       arst_n_i,
  input  wire logic [3:0] cap_i,
  input  wire logic       heavy_i,
  input  wire logic [3:0] level_i,
  input  wire logic [1:0] margin_i,
  input  wire logic [4:0] sw_i,
  output logic            below_precharge_o,
  output logic            above_output_o,
  output logic [3:0]      voltage_o,
  output logic            residual_above_o,
  output logic            below_target_o,
  output logic            peak_trip_o,
  output logic            zero_cross_o
);
  logic [4:0] last;
  logic [3:0] cnt;

  assign below_precharge_o = cap_i < PRECHARGE_CODE;
  assign above_output_o    = cap_i > level_i;
  assign voltage_o         = cap_i;
  assign residual_above_o  = cap_i > {2'b00, margin_i};
  assign below_target_o    = heavy_i;

  // inductor current ramps while one switch set stays closed
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      last         <= 5'h00;
      cnt          <= 4'h0;
      peak_trip_o  <= 1'b0;
      zero_cross_o <= 1'b0;
    end else begin
      last         <= sw_i;
      cnt          <= (sw_i != last || sw_i == 5'h00) ? 4'h0 : (cnt == 4'hF ? cnt : cnt + 4'h1);
      peak_trip_o  <= cnt == TRIP_CNT;
      zero_cross_o <= cnt == EMPTY_CNT && !heavy_i;
    end
  end
endmodule // storage_load_model

// [test/testbench.sv]
// Purpose: self-checking bench for the power-stage control block
// Assumes: register port with one-cycle strobes, read data one cycle later
// Notes:   register rows first, then hand-written state scenarios

`timescale 1ns/1ps

// ************************************************************
// testbench
// ************************************************************
module testbench;
  typedef struct packed {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_t;
  logic mclk_i, arst_n_i, wr_i, rd_i, heavy, below_pc, above_out, resid, below_tgt, peak, zc;
  logic [7:0] addr_i, wdata_i, rdata_o, rv;
  logic [3:0] cap, svolt, level, tgt;
  logic [1:0] marg;
  logic ready, pre, leg, sa, sb, sc, sd, b2p, s2p, b2s, r2s, eoc;
  booster_pkg::pwr_state_t pwr;
  int err_total, checks_done;
  row_t rows[15] = '{{1'b0,8'h00,8'h00,8'h00}, {1'b0,8'h07,8'h00,8'h01}, {1'b0,8'h08,8'h00,8'h01},
    {1'b0,8'h09,8'h00,8'h06}, {1'b0,8'h10,8'h00,8'h00}, {1'b0,8'h11,8'h00,8'h00}, {1'b0,8'h13,8'h00,8'h03},
    {1'b1,8'h05,8'hFF,8'h00}, {1'b1,8'h00,8'hFF,8'h00}, {1'b1,8'h09,8'h03,8'h03}, {1'b1,8'h13,8'h01,8'h01},
    {1'b1,8'h08,8'h2A,8'h2A}, {1'b1,8'h07,8'h01,8'h01}, {1'b1,8'h13,8'h03,8'h03}, {1'b1,8'h09,8'h06,8'h06}};

  power_stage_ctl DUT (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .pwr_state_i(pwr), .out_below_target_i(below_tgt),
    .storage_below_precharge_i(below_pc), .storage_above_output_i(above_out), .storage_voltage_i(svolt),
    .residual_above_margin_i(resid), .peak_trip_i(peak), .zero_cross_i(zc), .ready_o(ready),
    .precharge_switch_o(pre), .precharge_leg_switch_o(leg), .bridge_switch_a_o(sa), .bridge_switch_b_o(sb),
    .bridge_switch_c_o(sc), .bridge_switch_d_o(sd), .battery_to_permanent_switch_o(b2p),
    .switched_to_permanent_switch_o(s2p), .battery_to_switched_switch_o(b2s),
    .regulator_to_switched_switch_o(r2s), .output_level_o(level), .learned_charge_target_o(tgt),
    .opt_margin_o(marg), .end_of_charge_o(eoc));

  storage_load_model far_side (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .cap_i(cap), .heavy_i(heavy),
    .level_i(level), .margin_i(marg), .sw_i({leg, sa, sb, sc, sd}), .below_precharge_o(below_pc),
    .above_output_o(above_out), .voltage_o(svolt), .residual_above_o(resid), .below_target_o(below_tgt),
    .peak_trip_o(peak), .zero_cross_o(zc));

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    checks_done++;
    if (s !== e) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr_i <= a; wdata_i <= d; wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    addr_i <= a; rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask

  task automatic set_st(input booster_pkg::pwr_state_t s, input logic [3:0] c, input logic h);
    @(posedge mclk_i);
    pwr <= s; cap <= c; heavy <= h;
  endtask

  // watches the switch vector {leg,a,b,c,d} over three switching periods
  task automatic conv(input booster_pkg::pwr_state_t s, input logic [3:0] c, input logic [4:0] p,
                      input logic [4:0] q, input string n);
    logic [4:0] v, pv;
    int t0, per, bad;
    logic sp, sq;
    pv = 5'h00; t0 = -1; per = 0; bad = 0; sp = 1'b0; sq = 1'b0;
    set_st(s, c, 1'b0);
    for (int i = 0; i < 400; i++) begin
      cyc(1);
      v = {leg, sa, sb, sc, sd};
      if ((v !== 5'h00 && v !== p && v !== q) || (pv === p && v === q)) bad++;
      if (v === p && pv !== p) begin
        if (t0 >= 0) per = i - t0;
        t0 = i;
      end
      sp = sp | (v === p);
      sq = sq | (v === q);
      pv = v;
    end
    chk({n, " overlap"}, 8'h00, 8'(bad));
    chk({n, " primary"}, 8'h01, {7'h00, sp});
    chk({n, " secondary"}, 8'h01, {7'h00, sq});
    chk({n, " period"}, 8'(booster_pkg::SW_PERIOD_CYC), 8'(per));
    $display("test %s done", n);
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end

  initial begin
    repeat (20000) @(posedge mclk_i);
    err_total++;
    print_verdict();
  end

  initial begin
    err_total = 0; checks_done = 0; arst_n_i = 1'b0; addr_i = 8'h00; wdata_i = 8'h00; wr_i = 1'b0;
    rd_i = 1'b0; pwr = booster_pkg::ST_STANDBY; cap = 4'h0; heavy = 1'b0;
    repeat (5) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    cyc(2);
    chk("ready", 8'h01, {7'h00, ready});
    chk("routing", 8'h0A, {4'h0, b2p, s2p, b2s, r2s});
    chk("level", 8'h06, {4'h0, level});
    chk("margin", 8'h03, {6'h00, marg});
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rv);
      chk("register", rows[i].e, rv);
    end
    $display("test registers done");
    set_st(booster_pkg::ST_CHARGE, 4'h1, 1'b0);
    cyc(3);
    chk("precharge", 8'h20, {2'b00, pre, leg, sa, sb, sc, sd});
    chk("eoc low", 8'h00, {7'h00, eoc});
    conv(booster_pkg::ST_CHARGE, 4'h8, 5'h12, 5'h05, "charge boost");
    conv(booster_pkg::ST_ACTIVE, 4'hF, 5'h09, 5'h03, "active buck");
    conv(booster_pkg::ST_ACTIVE, 4'h4, 5'h05, 5'h09, "active boost");
    cyc(3);
    chk("active routing", 8'h05, {4'h0, b2p, s2p, b2s, r2s});
    wr(8'h09, 8'h0C);
    cyc(1);
    chk("level live", 8'h0C, {4'h0, level});
    set_st(booster_pkg::ST_ACTIVE, 4'hF, 1'b1);
    set_st(booster_pkg::ST_ACTIVE, 4'hF, 1'b0);
    cyc(3);
    chk("alarm pin", 8'h00, {7'h00, ready});
    rd(8'h00, rv);
    chk("alarm bit", 8'h20, rv);
    cyc(20);
    chk("alarm latched", 8'h00, {7'h00, ready});
    set_st(booster_pkg::ST_STANDBY, 4'hF, 1'b0);
    cyc(3);
    chk("leave active", 8'h0E, {4'h0, tgt});
    chk("standby alarm", 8'h00, {7'h00, ready});
    set_st(booster_pkg::ST_CHARGE, 4'hF, 1'b0);
    cyc(3);
    chk("alarm clear", 8'h01, {7'h00, ready});
    chk("eoc", 8'h01, {7'h00, eoc});
    set_st(booster_pkg::ST_STANDBY, 4'hF, 1'b1);
    set_st(booster_pkg::ST_STANDBY, 4'hF, 1'b0);
    cyc(3);
    chk("no alarm outside", 8'h01, {7'h00, ready});
    $display("test alarm done");
    wr(8'h10, 8'h10);
    cyc(3);
    chk("float standby", 8'h08, {4'h0, b2p, s2p, b2s, r2s});
    set_st(booster_pkg::ST_CHARGE, 4'h1, 1'b0);
    cyc(3);
    chk("float charge", 8'h08, {4'h0, b2p, s2p, b2s, r2s});
    wr(8'h10, 8'h00);
    cyc(3);
    chk("float off", 8'h0A, {4'h0, b2p, s2p, b2s, r2s});
    wr(8'h11, 8'h05);
    wr(8'h07, 8'h00);
    cyc(3);
    chk("fixed target", 8'h05, {4'h0, tgt});
    wr(8'h08, 8'h3F);
    cyc(3);
    chk("profile 63", 8'h0F, {4'h0, tgt});
    wr(8'h07, 8'h01);
    cyc(3);
    chk("profile kept", 8'h0E, {4'h0, tgt});
    set_st(booster_pkg::ST_ACTIVE, 4'h2, 1'b0);
    cyc(3);
    set_st(booster_pkg::ST_STANDBY, 4'h2, 1'b0);
    cyc(3);
    chk("learn up", 8'h0F, {4'h0, tgt});
    $display("test optimizer done");
    wr(8'h10, 8'h10);
    wr(8'h09, 8'h03);
    wr(8'h07, 8'h00);
    rd(8'h09, rv);
    chk("read back", 8'h03, rv);
    cyc(1);
    chk("read once", 8'h00, rdata_o);
    @(posedge mclk_i);
    arst_n_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    cyc(2);
    chk("reset routing", 8'h0A, {4'h0, b2p, s2p, b2s, r2s});
    chk("reset level", 8'h06, {4'h0, level});
    chk("reset target", 8'h0F, {4'h0, tgt});
    $display("test reset done");
    print_verdict();
  end
endmodule // testbench
